// *** rtl/spms_io_pins.v ***
// Six multi-purpose pins: input sampling, wake detection, safety pairs and gate drive.
`timescale 1ns/10ps
`include "spms_map.vh"
module spms_io_pins #(
    parameter N = 6
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire [N-1:0] io_pin_i,
    input wire [2*N-1:0] io_func_i,
    input wire [2*N-1:0] io_wake_mode_i,
    input wire [N-1:0] io_gate_on_i,
    input wire wake_arm_i,
    output reg [N-1:0] io_level_o,
    output reg [N-1:0] io_wake_hit_o,
    output reg [2:0] safety_err_o,
    output reg [N-1:0] io_gate_o,
    output reg [N-1:0] io_gate_oe_o
);
    // Previous level of each pin, used for edge and state-change detection.
    reg [N-1:0] prev_reg;
    // Per-pin combinational wake hit.
    reg [N-1:0] hit_next;
    integer k;

    // Wake detection compares each pin with its previous sample.
    always @* begin
        hit_next = {N{1'b0}};
        for (k = 0; k < N; k = k + 1) begin
            if (io_func_i[2*k +: 2] == `SPMS_FN_WAKE) begin
                case (io_wake_mode_i[2*k +: 2])
                    `SPMS_WK_RISE: hit_next[k] = io_pin_i[k] & ~prev_reg[k];
                    `SPMS_WK_FALL: hit_next[k] = ~io_pin_i[k] & prev_reg[k];
                    `SPMS_WK_TOGGLE: hit_next[k] = io_pin_i[k] ^ prev_reg[k];
                    default: hit_next[k] = 1'b0;
                endcase
            end
        end
    end

    // Registered levels, wake hits and gate outputs.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            prev_reg <= {N{1'b0}};
            io_level_o <= {N{1'b0}};
            io_wake_hit_o <= {N{1'b0}};
            io_gate_o <= {N{1'b0}};
            io_gate_oe_o <= {N{1'b0}};
        end else begin
            prev_reg <= io_pin_i;
            io_level_o <= io_pin_i;
            io_wake_hit_o <= wake_arm_i ? hit_next : {N{1'b0}};
            // Only the last two pins can drive a low-side gate.
            io_gate_o <= {io_gate_on_i[N-1:N-2], {(N-2){1'b0}}};
            io_gate_oe_o[N-1] <= (io_func_i[2*N-1 -: 2] == `SPMS_FN_GATE);
            io_gate_oe_o[N-2] <= (io_func_i[2*N-3 -: 2] == `SPMS_FN_GATE);
            io_gate_oe_o[N-3:0] <= {(N-2){1'b0}};
        end
    end

    // Safety pairs: outer pairs flag a fault when the pair disagrees; the middle
    // pair uses a bistable protocol where the two pins must stay complementary.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            safety_err_o <= 3'h0;
        end else begin
            safety_err_o[0] <= (io_func_i[1:0] == `SPMS_FN_SAFE) &&
                               (io_func_i[3:2] == `SPMS_FN_SAFE) &&
                               (io_pin_i[0] ^ io_pin_i[1]);
            safety_err_o[1] <= (io_func_i[5:4] == `SPMS_FN_SAFE) &&
                               (io_func_i[7:6] == `SPMS_FN_SAFE) &&
                               (io_pin_i[2] == io_pin_i[3]);
            safety_err_o[2] <= (io_func_i[9:8] == `SPMS_FN_SAFE) &&
                               (io_func_i[11:10] == `SPMS_FN_SAFE) &&
                               (io_pin_i[4] ^ io_pin_i[5]);
        end
    end
endmodule

// *** rtl/spms_map.vh ***
// Constants for the power-mode sequencer: field positions, reset values and timing.
`ifndef SPMS_MAP_VH
`define SPMS_MAP_VH
// Clock rate in kHz (25 MHz).
`define SPMS_CLK_KHZ 25000
// Short fault-reset duration in microseconds.
`define SPMS_RST_SHORT_US 1000
// Long fault-reset duration in microseconds.
`define SPMS_RST_LONG_US 10000
// Longest reset duration, used after power-on and after sleep, in microseconds.
`define SPMS_RST_POR_US 13000
// Retry delay after a pre-regulator undervoltage, in microseconds.
`define SPMS_UV_RETRY_US 1000
// Soft-start durations in microseconds.
`define SPMS_PRE_SS_US 1000
`define SPMS_REG_SS_US 1000
// Wake mode encodings per pin.
`define SPMS_WK_OFF 2'h0
`define SPMS_WK_RISE 2'h1
`define SPMS_WK_FALL 2'h2
`define SPMS_WK_TOGGLE 2'h3
// Pin function encodings per pin.
`define SPMS_FN_DIN 2'h0
`define SPMS_FN_WAKE 2'h1
`define SPMS_FN_SAFE 2'h2
`define SPMS_FN_GATE 2'h3
// Wake source bit positions in the wake source vector.
`define SPMS_WSRC_CAN 6
// Reset value of the pulse width configuration.
`define SPMS_INT_WIDTH_RST 8'h19
`endif

// *** rtl/spms_sequencer.v ***
// Main power-mode sequencer with fail-safe, reset and interrupt outputs.
`timescale 1ns/10ps
`include "spms_map.vh"
module spms_sequencer #(
    parameter N_IO = 6,
    parameter TW = 20,
    parameter POR_CYC = `SPMS_RST_POR_US * (`SPMS_CLK_KHZ / 1000),
    parameter LONG_CYC = `SPMS_RST_LONG_US * (`SPMS_CLK_KHZ / 1000),
    parameter SHORT_CYC = `SPMS_RST_SHORT_US * (`SPMS_CLK_KHZ / 1000),
    parameter RETRY_CYC = `SPMS_UV_RETRY_US * (`SPMS_CLK_KHZ / 1000),
    parameter PRE_SS_CYC = `SPMS_PRE_SS_US * (`SPMS_CLK_KHZ / 1000),
    parameter REG_SS_CYC = `SPMS_REG_SS_US * (`SPMS_CLK_KHZ / 1000)
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire low_side_gate_grounded_i,
    input wire [1:0] select_level_i,
    input wire select_to_pre_i,
    input wire pre_regulator_uv_i,
    input wire can_wake_i,
    input wire [N_IO-1:0] io_pin_i,
    input wire cfg_write_i,
    input wire [2*N_IO-1:0] cfg_io_func_i,
    input wire [2*N_IO-1:0] cfg_io_wake_mode_i,
    input wire [N_IO-1:0] cfg_io_gate_on_i,
    input wire [N_IO-1:0] cfg_wake_enable_i,
    input wire cfg_can_wake_enable_i,
    input wire cfg_init_write_i,
    input wire cfg_rst_long_i,
    input wire cfg_int_pulse_en_i,
    input wire [7:0] cfg_int_width_i,
    input wire cfg_safety_fs_en_i,
    input wire init_done_write_i,
    input wire low_power_off_cmd_i,
    input wire failsafe_release_i,
    input wire fault_event_i,
    input wire reset_fault_i,
    input wire int_event_i,
    output reg interrupt_out_n_o,
    output reg failsafe_out_n_o,
    output reg mcu_reset_out_n_o,
    output reg pre_regulator_en_o,
    output reg core_supply_en_o,
    output reg aux_supply_en_o,
    output reg analog_supply_en_o,
    output reg buck_boost_o,
    output reg [1:0] supply_level_o,
    output reg [6:0] wake_source_o,
    output wire [N_IO-1:0] io_level_o,
    output wire [2:0] safety_err_o,
    output wire [N_IO-1:0] io_gate_o,
    output wire [N_IO-1:0] io_gate_oe_o,
    output reg init_open_o,
    output reg normal_mode_o,
    output reg sleep_mode_o
);
    // One-hot states of the main machine.
    localparam [8:0] ST_TOPO = 9'h001;
    localparam [8:0] ST_PRE_ON = 9'h002;
    localparam [8:0] ST_SELECT = 9'h004;
    localparam [8:0] ST_REG_ON = 9'h008;
    localparam [8:0] ST_RESET = 9'h010;
    localparam [8:0] ST_INIT = 9'h020;
    localparam [8:0] ST_NORMAL = 9'h040;
    localparam [8:0] ST_SLEEP = 9'h080;
    localparam [8:0] ST_UV_OFF = 9'h100;

    // Current and next state.
    reg [8:0] state_reg;
    reg [8:0] state_next;
    // Configuration held by the block; init-only items lock on completion.
    reg [2*N_IO-1:0] io_func_reg;
    reg [2*N_IO-1:0] io_wake_mode_reg;
    reg [N_IO-1:0] io_gate_on_reg;
    reg [N_IO-1:0] wake_en_reg;
    reg can_wake_en_reg;
    reg rst_long_reg;
    reg int_pulse_en_reg;
    reg [7:0] int_width_reg;
    reg safety_fs_en_reg;
    // Pulse-width counter for the interrupt output.
    reg [7:0] int_cnt_reg;
    // Set when a fault reset is pending so the reset phase returns to normal instead of init.
    reg fault_rst_reg;
    // Timer control.
    reg tmr_load;
    reg [TW-1:0] tmr_count;
    wire tmr_done;
    // Pin wake hits from the pin block.
    wire [N_IO-1:0] io_wake_hit;
    wire any_wake;

    // Shared timer for soft starts, reset delays and undervoltage retry.
    spms_timer #(.W(TW)) u_timer (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .busy_o(),
        .done_o(tmr_done)
    );

    // Pin logic; wake detection is armed only while asleep.
    spms_io_pins #(.N(N_IO)) u_pins (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .io_pin_i(io_pin_i),
        .io_func_i(io_func_reg),
        .io_wake_mode_i(io_wake_mode_reg),
        .io_gate_on_i(io_gate_on_reg),
        .wake_arm_i(state_reg == ST_SLEEP),
        .io_level_o(io_level_o),
        .io_wake_hit_o(io_wake_hit),
        .safety_err_o(safety_err_o),
        .io_gate_o(io_gate_o),
        .io_gate_oe_o(io_gate_oe_o)
    );

    assign any_wake = (|(io_wake_hit & wake_en_reg)) | (can_wake_i & can_wake_en_reg);

    // Next-state logic; each timed phase loads the timer on entry.
    always @* begin
        state_next = state_reg;
        tmr_load = 1'b0;
        tmr_count = {TW{1'b0}};
        case (state_reg)
            ST_TOPO: begin
                state_next = ST_PRE_ON;
                tmr_load = 1'b1;
                tmr_count = PRE_SS_CYC[TW-1:0];
            end
            ST_PRE_ON: begin
                if (tmr_done) begin
                    state_next = ST_SELECT;
                end
            end
            ST_SELECT: begin
                state_next = ST_REG_ON;
                tmr_load = 1'b1;
                tmr_count = REG_SS_CYC[TW-1:0];
            end
            ST_REG_ON: begin
                if (tmr_done) begin
                    state_next = ST_RESET;
                    tmr_load = 1'b1;
                    tmr_count = POR_CYC[TW-1:0];
                end
            end
            ST_RESET: begin
                if (tmr_done) begin
                    state_next = fault_rst_reg ? ST_NORMAL : ST_INIT;
                end
            end
            ST_INIT, ST_NORMAL: begin
                if (pre_regulator_uv_i) begin
                    state_next = ST_UV_OFF;
                    tmr_load = 1'b1;
                    tmr_count = RETRY_CYC[TW-1:0];
                end else if (reset_fault_i && state_reg == ST_NORMAL) begin
                    state_next = ST_RESET;
                    tmr_load = 1'b1;
                    tmr_count = rst_long_reg ? LONG_CYC[TW-1:0] : SHORT_CYC[TW-1:0];
                end else if (state_reg == ST_INIT && init_done_write_i) begin
                    state_next = ST_NORMAL;
                end else if (state_reg == ST_NORMAL && low_power_off_cmd_i) begin
                    state_next = ST_SLEEP;
                end
                // A sleep command in init falls through, so the mode is kept.
            end
            ST_SLEEP: begin
                if (any_wake) begin
                    state_next = ST_TOPO;
                end
            end
            ST_UV_OFF: begin
                if (tmr_done) begin
                    state_next = ST_TOPO;
                end
            end
            default: state_next = ST_TOPO;
        endcase
    end

    // State register, supply enables, reset and mode outputs.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            state_reg <= ST_TOPO;
            pre_regulator_en_o <= 1'b0;
            core_supply_en_o <= 1'b0;
            aux_supply_en_o <= 1'b0;
            analog_supply_en_o <= 1'b0;
            buck_boost_o <= 1'b0;
            supply_level_o <= 2'h0;
            mcu_reset_out_n_o <= 1'b0;
            fault_rst_reg <= 1'b0;
            wake_source_o <= 7'h00;
            init_open_o <= 1'b0;
            normal_mode_o <= 1'b0;
            sleep_mode_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            init_open_o <= (state_next == ST_INIT);
            normal_mode_o <= (state_next == ST_NORMAL);
            sleep_mode_o <= (state_next == ST_SLEEP);
            // The reset output is low in every phase before init or normal.
            mcu_reset_out_n_o <= (state_next == ST_INIT) || (state_next == ST_NORMAL);
            if (state_reg == ST_TOPO) begin
                buck_boost_o <= ~low_side_gate_grounded_i;
                pre_regulator_en_o <= 1'b1;
                fault_rst_reg <= 1'b0;
            end
            if (state_reg == ST_SELECT) begin
                supply_level_o <= select_level_i;
                core_supply_en_o <= 1'b1;
                analog_supply_en_o <= 1'b1;
                aux_supply_en_o <= ~select_to_pre_i;
            end
            if (state_next == ST_RESET && state_reg == ST_NORMAL) begin
                fault_rst_reg <= 1'b1;
            end
            if (state_next == ST_SLEEP || state_next == ST_UV_OFF) begin
                // Everything off; the microcontroller loses its supply.
                pre_regulator_en_o <= 1'b0;
                core_supply_en_o <= 1'b0;
                aux_supply_en_o <= 1'b0;
                analog_supply_en_o <= 1'b0;
            end
            if (state_reg == ST_SLEEP && any_wake) begin
                wake_source_o <= {can_wake_i & can_wake_en_reg, io_wake_hit & wake_en_reg};
            end
        end
    end

    // Configuration: init-only fields accept writes only in init; others also in normal.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            io_func_reg <= {(2*N_IO){1'b0}};
            io_wake_mode_reg <= {(2*N_IO){1'b0}};
            io_gate_on_reg <= {N_IO{1'b0}};
            wake_en_reg <= {N_IO{1'b0}};
            can_wake_en_reg <= 1'b1;
            rst_long_reg <= 1'b1;
            int_pulse_en_reg <= 1'b1;
            int_width_reg <= `SPMS_INT_WIDTH_RST;
            safety_fs_en_reg <= 1'b0;
        end else begin
            if (cfg_init_write_i && state_reg == ST_INIT) begin
                rst_long_reg <= cfg_rst_long_i;
                int_pulse_en_reg <= cfg_int_pulse_en_i;
                int_width_reg <= cfg_int_width_i;
                io_func_reg <= cfg_io_func_i;
                safety_fs_en_reg <= cfg_safety_fs_en_i;
            end
            if (cfg_write_i && (state_reg == ST_INIT || state_reg == ST_NORMAL)) begin
                io_wake_mode_reg <= cfg_io_wake_mode_i;
                io_gate_on_reg <= cfg_io_gate_on_i;
                wake_en_reg <= cfg_io_wake_mode_i != {(2*N_IO){1'b0}} ? cfg_wake_enable_i : {N_IO{1'b0}};
                can_wake_en_reg <= cfg_can_wake_enable_i;
            end
        end
    end

    // Fail-safe output: low after power-on and wake, low on a fault, released by software.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            failsafe_out_n_o <= 1'b0;
        end else if (state_reg == ST_TOPO) begin
            failsafe_out_n_o <= 1'b0;
        end else if (fault_event_i || (safety_fs_en_reg && (|safety_err_o))) begin
            // A fault in the same cycle as a release keeps the pin low.
            failsafe_out_n_o <= 1'b0;
        end else if (failsafe_release_i && (state_reg == ST_INIT || state_reg == ST_NORMAL)) begin
            failsafe_out_n_o <= 1'b1;
        end
    end

    // Interrupt pulse: width counted in clock cycles; a new event restarts it.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            int_cnt_reg <= 8'h00;
            interrupt_out_n_o <= 1'b1;
        end else if (int_event_i && int_pulse_en_reg && int_width_reg != 8'h00) begin
            int_cnt_reg <= int_width_reg;
            interrupt_out_n_o <= 1'b0;
        end else if (int_cnt_reg > 8'h01) begin
            int_cnt_reg <= int_cnt_reg - 8'h01;
        end else begin
            int_cnt_reg <= 8'h00;
            interrupt_out_n_o <= 1'b1;
        end
    end
endmodule

// *** rtl/spms_timer.v ***
// Down-counting timer that pulses done once after a load.
`timescale 1ns/10ps
module spms_timer #(
    parameter W = 20
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire load_i,
    input wire [W-1:0] count_i,
    output wire busy_o,
    output reg done_o
);
    // Remaining cycles; zero means idle.
    reg [W-1:0] cnt_reg;

    // A load restarts the count even while busy, so the latest request wins.
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            cnt_reg <= {W{1'b0}};
            done_o <= 1'b0;
        end else if (load_i) begin
            cnt_reg <= count_i;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
            if (cnt_reg != {W{1'b0}}) begin
                cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign busy_o = (cnt_reg != {W{1'b0}});
endmodule

// *** testbench/spms_mcu_model.sv ***
// Behavioural microcontroller: software writes and bistable error pins.
`timescale 1ns/10ps
module spms_mcu_model (
    input wire mclk_i,
    input wire mcu_reset_n_i,
    input wire core_on_i,
    input wire [3:0] req_i,
    input wire err_i,
    output reg [3:0] sw_o,
    output wire [1:0] err_pins_o
);
    // A controller in reset or unpowered cannot issue any write.
    wire powered = mcu_reset_n_i & core_on_i;
    initial sw_o = 4'h0;
    // Writes leave on the falling edge and last one cycle.
    always @(negedge mclk_i) begin
        sw_o <= req_i & {4{powered}};
    end
    // Healthy pair is complementary; unpowered pins sit low.
    assign err_pins_o = !core_on_i ? 2'h0 : (err_i ? 2'h3 : 2'h1);
endmodule

// *** testbench/spms_seq_asserts.sv ***
// Port-level checks for the power-mode sequencer.
`timescale 1ns/10ps
module spms_seq_asserts (
    input wire mclk_i,
    input wire resetn_i,
    input wire select_to_pre_i,
    input wire pre_regulator_uv_i,
    input wire init_done_write_i,
    input wire low_power_off_cmd_i,
    input wire failsafe_release_i,
    input wire fault_event_i,
    input wire failsafe_out_n_o,
    input wire mcu_reset_out_n_o,
    input wire pre_regulator_en_o,
    input wire core_supply_en_o,
    input wire aux_supply_en_o,
    input wire analog_supply_en_o,
    input wire init_open_o,
    input wire normal_mode_o,
    input wire sleep_mode_o
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    AST_RST_HIGH_ONLY_RUN: assert property (mcu_reset_out_n_o |-> (init_open_o || normal_mode_o))
        else $error("reset released outside init or normal");
    AST_SLEEP_ALL_OFF: assert property (sleep_mode_o |-> !pre_regulator_en_o && !core_supply_en_o
        && !mcu_reset_out_n_o)
        else $error("supply or reset active in sleep");
    AST_SLEEP_REFUSED: assert property (low_power_off_cmd_i && !normal_mode_o && !sleep_mode_o
        |=> !sleep_mode_o)
        else $error("sleep entered outside normal");
    AST_INIT_TO_NORMAL: assert property (init_open_o && init_done_write_i && !pre_regulator_uv_i
        |=> normal_mode_o)
        else $error("init completion did not reach normal");
    AST_FS_RELEASE_ONLY: assert property ($rose(failsafe_out_n_o) |-> $past(failsafe_release_i)
        && !$past(fault_event_i))
        else $error("failsafe rose without release");
    AST_FAULT_FS_LOW: assert property (fault_event_i |=> !failsafe_out_n_o)
        else $error("fault left failsafe high");
    AST_UV_ALL_OFF: assert property (pre_regulator_uv_i && (init_open_o || normal_mode_o)
        |=> !pre_regulator_en_o && !core_supply_en_o)
        else $error("undervoltage left supplies on");
    AST_REGS_TOGETHER: assert property ($rose(core_supply_en_o) |-> analog_supply_en_o
        && (aux_supply_en_o == !$past(select_to_pre_i)))
        else $error("regulators not switched together");
    cover property ($rose(normal_mode_o));
    cover property ($rose(sleep_mode_o));
    cover property ($fell(failsafe_out_n_o));
endmodule
bind spms_sequencer spms_seq_asserts chk_u (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .select_to_pre_i(select_to_pre_i), .pre_regulator_uv_i(pre_regulator_uv_i),
    .init_done_write_i(init_done_write_i), .low_power_off_cmd_i(low_power_off_cmd_i),
    .failsafe_release_i(failsafe_release_i), .fault_event_i(fault_event_i),
    .failsafe_out_n_o(failsafe_out_n_o), .mcu_reset_out_n_o(mcu_reset_out_n_o),
    .pre_regulator_en_o(pre_regulator_en_o), .core_supply_en_o(core_supply_en_o),
    .aux_supply_en_o(aux_supply_en_o), .analog_supply_en_o(analog_supply_en_o),
    .init_open_o(init_open_o), .normal_mode_o(normal_mode_o), .sleep_mode_o(sleep_mode_o));

// *** testbench/tb.sv ***
// Self-checking bench for the power-mode sequencer.
`timescale 1ns/10ps
module tb;
    localparam P_PRE = 8, P_REG = 8, P_POR = 30, P_LONG = 20, P_SHORT = 10, P_RETRY = 15;
    reg mclk = 1'h0, rstn = 1'h0, gate_gnd = 1'h1, sel_pre = 1'h0, uv = 1'h0, can_wk = 1'h0;
    reg cfg_w = 1'h0, rst_long = 1'h1, ipe = 1'h0, sfs = 1'h0, rfault = 1'h0, fault = 1'h0;
    reg iev = 1'h0, can_en = 1'h0, mcu_err = 1'h0;
    reg [1:0] sel_lvl = 2'h2;
    reg [5:0] pins = 6'h00, gate_on = 6'h00, wk_en = 6'h00;
    reg [11:0] func = 12'h000, wmode = 12'h000;
    reg [7:0] iw = 8'h19;
    reg [3:0] req = 4'h0;
    wire [3:0] sw;
    wire [1:0] mpins, lvl_o;
    wire [5:0] lvl, gate, gate_oe;
    wire [6:0] wsrc;
    wire [2:0] serr;
    wire int_n, fs_n, rst_n, pre_en, core_en, aux_en, ana_en, bb, init_o, norm, slp;
    int fail_count = 0, samples_checked = 0;
    initial begin
        forever #20 mclk = ~mclk;
    end
    spms_mcu_model mcu_u (.mclk_i(mclk), .mcu_reset_n_i(rst_n), .core_on_i(core_en), .req_i(req),
        .err_i(mcu_err), .sw_o(sw), .err_pins_o(mpins));
    spms_sequencer #(.POR_CYC(P_POR), .LONG_CYC(P_LONG), .SHORT_CYC(P_SHORT), .RETRY_CYC(P_RETRY),
        .PRE_SS_CYC(P_PRE), .REG_SS_CYC(P_REG)) dut_u (.mclk_i(mclk), .resetn_i(rstn),
        .low_side_gate_grounded_i(gate_gnd), .select_level_i(sel_lvl), .select_to_pre_i(sel_pre),
        .pre_regulator_uv_i(uv), .can_wake_i(can_wk), .io_pin_i({pins[5:4], mpins, pins[1:0]}),
        .cfg_write_i(cfg_w), .cfg_io_func_i(func), .cfg_io_wake_mode_i(wmode), .cfg_io_gate_on_i(gate_on),
        .cfg_wake_enable_i(wk_en), .cfg_can_wake_enable_i(can_en), .cfg_init_write_i(sw[0]),
        .cfg_rst_long_i(rst_long), .cfg_int_pulse_en_i(ipe), .cfg_int_width_i(iw), .cfg_safety_fs_en_i(sfs),
        .init_done_write_i(sw[1]), .low_power_off_cmd_i(sw[3]), .failsafe_release_i(sw[2]),
        .fault_event_i(fault), .reset_fault_i(rfault), .int_event_i(iev), .interrupt_out_n_o(int_n),
        .failsafe_out_n_o(fs_n), .mcu_reset_out_n_o(rst_n), .pre_regulator_en_o(pre_en),
        .core_supply_en_o(core_en), .aux_supply_en_o(aux_en), .analog_supply_en_o(ana_en),
        .buck_boost_o(bb), .supply_level_o(lvl_o), .wake_source_o(wsrc), .io_level_o(lvl),
        .safety_err_o(serr), .io_gate_o(gate), .io_gate_oe_o(gate_oe), .init_open_o(init_o),
        .normal_mode_o(norm), .sleep_mode_o(slp));
    task automatic results;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_cnt(input int n, input int lo, input int hi, input string what);
        samples_checked++;
        if (n < lo || n > hi) begin
            fail_count++;
            $display("[FAIL] %0t %s count %0d", $time, what, n);
        end
    endtask
    function automatic logic probe(input int s);
        case (s)
            0: probe = pre_en;
            1: probe = core_en;
            2: probe = rst_n;
            4: probe = norm;
            default: probe = int_n;
        endcase
    endfunction
    // Bounded wait on a falling edge grid; a timeout ends the run.
    task automatic wait_val(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (probe(s) !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
        if (probe(s) !== v) begin
            fail_count++;
            $display("[FAIL] %0t wait timed out on %0d", $time, s);
            results;
        end
    endtask
    // One software write through the controller model; caller is on a falling edge.
    task automatic sw_op(input logic [3:0] op);
        req <= op;
        @(negedge mclk);
        req <= 4'h0;
        @(negedge mclk);
        @(negedge mclk);
    endtask
    task automatic pulse_cfg;
        cfg_w = 1'h1;
        @(negedge mclk);
        cfg_w = 1'h0;
        @(negedge mclk);
    endtask
    task automatic power_up;
        int n;
        wait_val(0, 1'h1, 20, n);
        wait_val(1, 1'h1, P_PRE + 20, n);
        chk_cnt(n, P_PRE, P_PRE + 10, "pre soft start");
        chk(aux_en, !sel_pre, "aux");
        chk(ana_en, 1'h1, "analog");
        chk(bb, !gate_gnd, "topology");
        chk(lvl_o, sel_lvl, "level");
        wait_val(2, 1'h1, P_REG + P_POR + 20, n);
        chk_cnt(n, P_POR, P_REG + P_POR + 10, "start reset");
        chk(fs_n, 1'h0, "failsafe at start");
        chk(init_o, 1'h1, "init open");
    endtask
    task automatic configure;
        func = 12'h7AA;
        rst_long = 1'h0;
        ipe = 1'h1;
        iw = 8'h04;
        gate_on = 6'h10;
        wmode = 12'h400;
        wk_en = 6'h20;
        can_en = 1'h1;
        pins[1:0] = 2'h2;
        sw_op(4'h1);
        pulse_cfg;
        chk(lvl[1:0], 2'h2, "digital level");
        chk({gate_oe[5:4], gate[5:4]}, 8'h05, "gate drive");
        chk(serr[1], 1'h0, "mcu pair ok");
        chk({serr[2], serr[0]}, 8'h01, "ext pairs");
        mcu_err = 1'h1;
        repeat (3) @(negedge mclk);
        chk(serr[1], 1'h1, "mcu pair error");
        mcu_err = 1'h0;
    endtask
    task automatic int_test;
        int n;
        iev = 1'h1;
        @(negedge mclk);
        iev = 1'h0;
        wait_val(5, 1'h0, 5, n);
        wait_val(5, 1'h1, 300, n);
        chk_cnt(n, 4, 4, "interrupt width");
    endtask
    task automatic fs_test;
        sw_op(4'h4);
        chk(fs_n, 1'h1, "release");
        fault = 1'h1;
        @(negedge mclk);
        fault = 1'h0;
        @(negedge mclk);
        chk(fs_n, 1'h0, "fault");
        sw_op(4'h4);
        chk(fs_n, 1'h1, "release again");
    endtask
    task automatic normal_test;
        int n;
        sw_op(4'h2);
        chk({norm, init_o}, 8'h02, "normal");
        rst_long = 1'h1;
        sw_op(4'h1);
        rfault = 1'h1;
        @(negedge mclk);
        rfault = 1'h0;
        wait_val(2, 1'h0, 5, n);
        wait_val(2, 1'h1, P_LONG + 10, n);
        chk_cnt(n, P_SHORT - 1, P_SHORT + 2, "fault reset");
        wait_val(4, 1'h1, 5, n);
    endtask
    task automatic sleep_test(input logic use_can);
        int n;
        // Idle level is high for the falling and toggle wake modes.
        pins[5] = wmode[11];
        pulse_cfg;
        sw_op(4'h8);
        chk(slp, 1'h1, "sleep");
        chk({pre_en, core_en, aux_en, ana_en, rst_n}, 8'h00, "off in sleep");
        if (use_can) begin
            can_wk = 1'h1;
        end else begin
            pins[5] = ~pins[5];
        end
        wait_val(0, 1'h1, 10, n);
        can_wk = 1'h0;
        chk(wsrc[6:5], use_can ? 2'h2 : 2'h1, "wake source");
        power_up;
    endtask
    task automatic uv_test;
        int n;
        uv = 1'h1;
        repeat (2) @(negedge mclk);
        chk({pre_en, core_en, aux_en, ana_en}, 8'h00, "uv off");
        uv = 1'h0;
        wait_val(0, 1'h1, P_RETRY + 10, n);
        chk_cnt(n, P_RETRY - 3, P_RETRY + 3, "uv retry");
        power_up;
    endtask
    initial begin
        repeat (20) @(negedge mclk);
        rstn = 1'h1;
        power_up;
        sw_op(4'h8);
        chk(slp, 1'h0, "early sleep");
        configure;
        int_test;
        fs_test;
        normal_test;
        sleep_test(1'h0);
        sw_op(4'h2);
        wmode = 12'h800;
        sleep_test(1'h0);
        sw_op(4'h2);
        wmode = 12'hC00;
        sleep_test(1'h0);
        sw_op(4'h2);
        gate_gnd = 1'h0;
        sel_pre = 1'h1;
        sel_lvl = 2'h1;
        sleep_test(1'h1);
        uv_test;
        results;
    end
    initial begin
        repeat (50000) @(posedge mclk);
        fail_count++;
        results;
    end
endmodule
